// file: verilog/xbpm_defines.vh
// Constants for the expansion bus pin-mode controller.
// Assumes inclusion by bare name from design files under verilog/.
`ifndef XBPM_DEFINES_VH
`define XBPM_DEFINES_VH
// Boot word field positions on exp_data_pins
`define XBPM_BOOT_DIR_POL_BIT   0
`define XBPM_BOOT_BLAST_POL_BIT 1
`define XBPM_BOOT_ARB_EN_BIT    2
`define XBPM_BOOT_GLUELESS_BIT  3
`define XBPM_BOOT_RDY_USE_BIT   4
`define XBPM_BOOT_RESET         32'h0000_0000
// Access kinds on the request port
`define XBPM_KIND_FIFO_RD       3'h0
`define XBPM_KIND_FIFO_WR       3'h1
`define XBPM_KIND_ASYNC_RD      3'h2
`define XBPM_KIND_ASYNC_WR      3'h3
`define XBPM_KIND_MASTER_RD     3'h4
`define XBPM_KIND_MASTER_WR     3'h5
// Glueless FIFO read space
`define XBPM_GLUELESS_SPACE     2'h3
// Asynchronous strobe timing in cycles
`define XBPM_SETUP_CYC          4'h2
`define XBPM_STROBE_CYC         4'h3
`define XBPM_HOLD_CYC           4'h1
`endif

// file: verilog/xbpm_arbiter.v
// Expansion bus ownership arbiter between the device and an external master.
// Assumes host_req/ext_grant come synchronous to sys_clk.
`timescale 1ns/1ps
module xbpm_arbiter (
   input  wire       sys_clk,
   input  wire       reset_n,
   input  wire       arb_en,
   input  wire       dev_req,
   input  wire       host_req,
   input  wire       ext_grant,
   output reg        dev_own_ff,
   output reg        host_own_ff
);
   ////////////////////////////////////////////////////////////////////////
   // Internal arbiter grants on idle bus; device wins ties. External one
   // only hands the bus to us, host then owns when we are not granted.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dev_own_ff  <= 1'b0;
         host_own_ff <= 1'b0;
      end else if (arb_en) begin
         if (!dev_own_ff && !host_own_ff) begin
            dev_own_ff  <= dev_req;
            host_own_ff <= !dev_req && host_req;
         end else begin
            dev_own_ff  <= dev_own_ff && dev_req;
            host_own_ff <= host_own_ff && host_req;
         end
      end else begin
         dev_own_ff  <= dev_req && ext_grant;
         host_own_ff <= host_req && !ext_grant;
      end
   end
endmodule // xbpm_arbiter

// file: verilog/xbpm_core.v
// Expansion bus pin-mode controller: routes shared pins per access kind.
// Assumes all inputs synchronous to sys_clk; pad logic resolves enables.
// Operation
// - Data pins are sampled as the boot word at the first clock edge after reset release.
// - Glueless FIFO read is offered only in chip-select space 3.
// - FIFO accesses drive the shared lane pins as word address bits 3:0.
// - FIFO accesses use the write-strobe pin as an active-low write enable.
// - Asynchronous accesses treat the ready pin as an active-high input.
// - Asynchronous reads run either ignoring ready or stretched by it.
// - Direction pin polarity comes from the boot word, in and out.
// - Host-port accesses carry four active-low byte enables.
// - External host burst-last is read with the boot polarity.
// - External host accesses use an active-low ready driven by the target.
// - As master the device drives burst-last active low always.
// - As master the write-strobe pin acts as a wait output.
// - Ownership comes from the internal arbiter or an external one.
`timescale 1ns/1ps
`include "xbpm_defines.vh"
module xbpm_core (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire [31:0] exp_data_pins_in,
   input  wire        req_valid,
   input  wire [2:0]  req_kind,
   input  wire [1:0]  req_space,
   input  wire [3:0]  req_addr,
   input  wire [3:0]  req_lanes,
   input  wire        req_last,
   input  wire [31:0] req_wdata,
   input  wire        exp_ready_pin_in,
   input  wire        exp_backoff_in,
   input  wire        host_req,
   input  wire        ext_grant,
   input  wire        exp_direction_pin_in,
   input  wire        exp_burst_last_in,
   input  wire        exp_addr_strobe_n_in,
   input  wire        tgt_ready,
   output reg         req_ready_ff,
   output reg         done_ff,
   output reg         refused_ff,
   output reg  [31:0] rdata_ff,
   output reg  [31:0] boot_word_ff,
   output reg         host_write_ff,
   output reg         host_last_ff,
   output reg         host_start_ff,
   output reg  [31:0] exp_data_pins_out,
   output reg         exp_data_pins_oe_n,
   output reg  [3:0]  exp_lane_pins_ff,
   output reg         exp_write_strobe_n_ff,
   output reg         exp_read_strobe_n_ff,
   output reg  [3:0]  exp_chip_select_n_ff,
   output reg         exp_addr_strobe_n_ff,
   output reg         exp_direction_pin_out,
   output reg         exp_direction_pin_oe_n,
   output reg         exp_burst_last_out,
   output reg         exp_burst_last_oe_n,
   output reg         exp_ready_pin_out,
   output reg         exp_ready_pin_oe_n,
   output reg         dev_owns_ff
);
   ////////////////////////////////////////////////////////////////////////
   localparam [5:0] ST_IDLE  = 6'b00_0001;
   localparam [5:0] ST_SETUP = 6'b00_0010;
   localparam [5:0] ST_STRB  = 6'b00_0100;
   localparam [5:0] ST_HOLD  = 6'b00_1000;
   localparam [5:0] ST_WAITG = 6'b01_0000;
   localparam [5:0] ST_BOFF  = 6'b10_0000;

   reg  [5:0] state_ff;
   reg  [3:0] cnt_ff;
   reg  [2:0] kind_ff;
   reg  [1:0] space_ff;
   reg  [3:0] addr_ff;
   reg  [3:0] lanes_ff;
   reg        last_ff;
   reg  [31:0] wdata_ff;
   reg        in_reset_ff;
   wire       dev_own;
   wire       host_own;
   wire       dir_pol   = boot_word_ff[`XBPM_BOOT_DIR_POL_BIT];
   wire       blast_pol = boot_word_ff[`XBPM_BOOT_BLAST_POL_BIT];
   wire       arb_en    = boot_word_ff[`XBPM_BOOT_ARB_EN_BIT];
   wire       glue_en   = boot_word_ff[`XBPM_BOOT_GLUELESS_BIT];
   wire       rdy_use   = boot_word_ff[`XBPM_BOOT_RDY_USE_BIT];

   // Kind decode shared by request check and pin routing
   function is_fifo;
      input [2:0] k;
      is_fifo = (k == `XBPM_KIND_FIFO_RD) || (k == `XBPM_KIND_FIFO_WR);
   endfunction
   function is_master;
      input [2:0] k;
      is_master = (k == `XBPM_KIND_MASTER_RD) || (k == `XBPM_KIND_MASTER_WR);
   endfunction
   function is_write;
      input [2:0] k;
      is_write = (k == `XBPM_KIND_FIFO_WR) || (k == `XBPM_KIND_ASYNC_WR) ||
                 (k == `XBPM_KIND_MASTER_WR);
   endfunction

   wire master_req = (state_ff == ST_WAITG) || (state_ff == ST_BOFF) ||
                     ((state_ff != ST_IDLE) && is_master(kind_ff));

   xbpm_arbiter u_arb (
      .sys_clk     (sys_clk),
      .reset_n     (reset_n),
      .arb_en      (arb_en),
      .dev_req     (master_req),
      .host_req    (host_req),
      .ext_grant   (ext_grant),
      .dev_own_ff  (dev_own),
      .host_own_ff (host_own)
   );

   ////////////////////////////////////////////////////////////////////////
   // Boot word: pins are read once, at the first clock edge after reset
   // release while the reset flag is still high; that sample is kept.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         in_reset_ff  <= 1'b1;
         boot_word_ff <= `XBPM_BOOT_RESET;
      end else begin
         in_reset_ff <= 1'b0;
         if (in_reset_ff)
            boot_word_ff <= exp_data_pins_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Device transfer sequencer
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff     <= ST_IDLE;
         cnt_ff       <= 4'h0;
         kind_ff      <= 3'h0;
         space_ff     <= 2'h0;
         addr_ff      <= 4'h0;
         lanes_ff     <= 4'h0;
         last_ff      <= 1'b0;
         wdata_ff     <= 32'h0000_0000;
         req_ready_ff <= 1'b0;
         done_ff      <= 1'b0;
         refused_ff   <= 1'b0;
         rdata_ff     <= 32'h0000_0000;
      end else begin
         done_ff    <= 1'b0;
         refused_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               req_ready_ff <= !in_reset_ff;
               if (req_valid && req_ready_ff) begin
                  req_ready_ff <= 1'b0;
                  // Glueless read needs space 3; elsewhere refuse it
                  if (req_kind == `XBPM_KIND_FIFO_RD && glue_en &&
                      req_space != `XBPM_GLUELESS_SPACE) begin
                     refused_ff <= 1'b1;
                  end else begin
                     kind_ff  <= req_kind;
                     space_ff <= req_space;
                     addr_ff  <= req_addr;
                     lanes_ff <= req_lanes;
                     last_ff  <= req_last;
                     wdata_ff <= req_wdata;
                     cnt_ff   <= `XBPM_SETUP_CYC;
                     state_ff <= is_master(req_kind) ? ST_WAITG : ST_SETUP;
                  end
               end
            end
            ST_WAITG: begin
               if (dev_own) begin
                  cnt_ff   <= `XBPM_SETUP_CYC;
                  state_ff <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (is_master(kind_ff) && exp_backoff_in) begin
                  state_ff <= ST_BOFF;
               end else if (cnt_ff <= 4'h1) begin
                  cnt_ff   <= `XBPM_STROBE_CYC;
                  state_ff <= ST_STRB;
               end else
                  cnt_ff <= cnt_ff - 4'h1;
            end
            ST_STRB: begin
               if (is_master(kind_ff) && exp_backoff_in) begin
                  state_ff <= ST_BOFF;
               end else if (cnt_ff > 4'h1) begin
                  cnt_ff <= cnt_ff - 4'h1;
               end else if (is_master(kind_ff) && exp_ready_pin_in) begin
                  cnt_ff <= cnt_ff; // Target holds active-low ready high
               end else if (!is_master(kind_ff) && !is_fifo(kind_ff) &&
                            rdy_use && !exp_ready_pin_in) begin
                  cnt_ff <= cnt_ff; // Stretch until peripheral ready
               end else begin
                  rdata_ff <= exp_data_pins_in;
                  cnt_ff   <= `XBPM_HOLD_CYC;
                  state_ff <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_ff > 4'h1)
                  cnt_ff <= cnt_ff - 4'h1;
               else begin
                  done_ff      <= 1'b1;
                  state_ff     <= ST_IDLE;
               end
            end
            ST_BOFF: begin
               // Bus released; retry whole transfer once back-off drops
               if (!exp_backoff_in)
                  state_ff <= ST_WAITG;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin routing by access kind; all pins parked high/released at idle, except ready, driven while the host owns
   wire active  = (state_ff == ST_SETUP) || (state_ff == ST_STRB) || (state_ff == ST_HOLD);
   wire strobe  = (state_ff == ST_STRB);
   wire wr      = is_write(kind_ff);
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         exp_data_pins_out      <= 32'h0000_0000;
         exp_data_pins_oe_n     <= 1'b1;
         exp_lane_pins_ff       <= 4'hF;
         exp_write_strobe_n_ff  <= 1'b1;
         exp_read_strobe_n_ff   <= 1'b1;
         exp_chip_select_n_ff   <= 4'hF;
         exp_addr_strobe_n_ff   <= 1'b1;
         exp_direction_pin_out  <= 1'b0;
         exp_direction_pin_oe_n <= 1'b1;
         exp_burst_last_out     <= 1'b1;
         exp_burst_last_oe_n    <= 1'b1;
         exp_ready_pin_out      <= 1'b1;
         exp_ready_pin_oe_n     <= 1'b1;
         dev_owns_ff            <= 1'b0;
         host_write_ff          <= 1'b0;
         host_last_ff           <= 1'b0;
         host_start_ff          <= 1'b0;
      end else begin
         dev_owns_ff           <= dev_own;
         exp_data_pins_out     <= wdata_ff;
         exp_data_pins_oe_n    <= !(active && wr && !in_reset_ff);
         exp_chip_select_n_ff  <= 4'hF;
         if (active && !is_master(kind_ff))
            exp_chip_select_n_ff[space_ff] <= 1'b0;
         // FIFO: lanes are address; others carry active-low byte enables
         if (active && is_fifo(kind_ff))
            exp_lane_pins_ff <= addr_ff;
         else if (active)
            exp_lane_pins_ff <= ~lanes_ff;
         else
            exp_lane_pins_ff <= 4'hF;
         // Shared strobe: FIFO write enable, or wait output as master
         if (active && is_master(kind_ff))
            exp_write_strobe_n_ff <= !(strobe && exp_ready_pin_in);
         else
            exp_write_strobe_n_ff <= !(strobe && wr);
         exp_read_strobe_n_ff  <= !(strobe && !wr);
         exp_addr_strobe_n_ff  <= !(state_ff == ST_SETUP && is_master(kind_ff));
         // Direction pin driven during our master cycles; level follows boot polarity
         exp_direction_pin_out  <= wr ^ dir_pol;
         exp_direction_pin_oe_n <= !(active && is_master(kind_ff));
         // Master burst-last always active low regardless of boot
         exp_burst_last_out  <= !(active && is_master(kind_ff) && last_ff);
         exp_burst_last_oe_n <= !(active && is_master(kind_ff));
         // Host targets us: decode its direction/last, answer low ready
         host_start_ff     <= host_own && !exp_addr_strobe_n_in;
         host_write_ff     <= exp_direction_pin_in ^ dir_pol;
         host_last_ff      <= exp_burst_last_in ^ !blast_pol;
         exp_ready_pin_out  <= !tgt_ready;
         exp_ready_pin_oe_n <= !host_own;
      end
   end
endmodule // xbpm_core

// file: verif/xbpm_chk.sv
// Port checker for the expansion bus pin-mode controller.
// Assumes the bench holds request fields from one take to the next.
`timescale 1ns/1ps
module xbpm_chk (
   input wire        sys_clk,
   input wire        reset_n,
   input wire        req_valid,
   input wire [2:0]  req_kind,
   input wire [1:0]  req_space,
   input wire [3:0]  req_addr,
   input wire [3:0]  req_lanes,
   input wire        req_last,
   input wire        exp_direction_pin_in,
   input wire        exp_burst_last_in,
   input wire        req_ready_ff,
   input wire        done_ff,
   input wire        refused_ff,
   input wire [31:0] boot_word_ff,
   input wire        host_write_ff,
   input wire        host_last_ff,
   input wire        host_start_ff,
   input wire [3:0]  exp_lane_pins_ff,
   input wire        exp_write_strobe_n_ff,
   input wire [3:0]  exp_chip_select_n_ff,
   input wire        exp_burst_last_out,
   input wire        exp_burst_last_oe_n,
   input wire        exp_direction_pin_out,
   input wire        exp_direction_pin_oe_n,
   input wire        dev_owns_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////
   // Request taken; a FIFO cycle with its chip select out
   wire take = req_valid && req_ready_ff;
   wire fsel = !req_kind[2] && !req_kind[1] && (exp_chip_select_n_ff != 4'hf);
   ////////////////////////////////////////////////////////////////
   boot_hold_a: assert property (req_ready_ff && $past(req_ready_ff) |-> $stable(boot_word_ff))
      else $error("boot word moved after release");
   refuse_a: assert property (take && req_kind == 3'h0 && boot_word_ff[3] && req_space != 2'h3 |=>
      refused_ff) else $error("glueless read outside space 3 not refused");
   fifo_addr_a: assert property (fsel |-> exp_lane_pins_ff == req_addr)
      else $error("fifo lanes not word address");
   fifo_we_a: assert property (fsel && req_kind[0] && $fell(exp_write_strobe_n_ff) |->
      !exp_write_strobe_n_ff [*3] ##1 exp_write_strobe_n_ff) else $error("fifo write enable width");
   sync_time_a: assert property (take && (req_kind == 3'h1 ||
      req_kind[2:1] == 2'b01 && !boot_word_ff[4]) |-> !done_ff [*7] ##1 done_ff)
      else $error("fixed strobe timing broken");
   master_lane_a: assert property (req_kind[2] && dev_owns_ff && exp_lane_pins_ff != 4'hf |->
      exp_lane_pins_ff == ~req_lanes) else $error("byte enables not active low");
   blast_low_a: assert property (!exp_burst_last_oe_n && dev_owns_ff && !exp_burst_last_out |->
      req_last) else $error("burst last not active low");
   host_dir_a: assert property (host_start_ff |->
      host_write_ff == ($past(exp_direction_pin_in) ^ boot_word_ff[0])) else $error("direction polarity wrong");
   host_last_a: assert property (host_start_ff |->
      host_last_ff == ($past(exp_burst_last_in) ~^ boot_word_ff[1])) else $error("host burst last polarity wrong");
   // Master kinds write when bit 0 is set; the driven level follows boot polarity
   dir_out_a: assert property (!exp_direction_pin_oe_n |->
      exp_direction_pin_out == (req_kind[0] ^ boot_word_ff[0])) else $error("direction output polarity wrong");
   // Main scenarios reached
   cover property (take && req_kind[2]);
   cover property (refused_ff);
   cover property (host_start_ff);
endmodule // xbpm_chk

bind xbpm_core xbpm_chk u_xbpm_chk (.sys_clk, .reset_n, .req_valid, .req_kind, .req_space, .req_addr, .req_lanes,
   .req_last, .exp_direction_pin_in, .exp_burst_last_in, .req_ready_ff, .done_ff, .refused_ff, .boot_word_ff,
   .host_write_ff, .host_last_ff, .host_start_ff, .exp_lane_pins_ff, .exp_write_strobe_n_ff,
   .exp_chip_select_n_ff, .exp_burst_last_out, .exp_burst_last_oe_n, .dev_owns_ff, .exp_direction_pin_out,
   .exp_direction_pin_oe_n);

// file: verif/xbpm_far_model.sv
// Far side model: boot straps, FIFO or peripheral, and a bus target.
// Assumes the bench sets ready lag and ready sense before each access.
`timescale 1ns/1ps
module xbpm_far_model (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        boot_mode,
   input  wire [31:0] boot_word,
   input  wire [31:0] rd_word,
   input  wire [3:0]  ready_lag,
   input  wire        ready_low,
   input  wire [3:0]  cs_n,
   input  wire        as_n,
   input  wire        rd_n,
   input  wire [31:0] dut_data,
   input  wire        dut_data_oe_n,
   input  wire        dut_rdy,
   input  wire        dut_rdy_oe_n,
   output wire [31:0] data_pins,
   output wire        ready_pin
);
   reg  [31:0] last_ff;
   reg  [3:0]  lag_ff;
   // Master cycles carry no chip select: the cycle stays open from the address
   // strobe through the read strobe or the driven write data
   wire        sel = (cs_n != 4'hf) || !as_n || !rd_n || !dut_data_oe_n;
   ////////////////////////////////////////////////////////////////
   // Count selected cycles; a released bus outside boot and read strobes never repeats its last word
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lag_ff <= 4'h0;
         last_ff <= 32'h0000_0000;
      end else begin
         lag_ff <= sel ? lag_ff + {3'h0, lag_ff != 4'hf} : 4'h0;
         last_ff <= data_pins;
      end
   end
   // DUT data while it drives, straps while booting, read word while strobed, else a toggling pattern
   assign data_pins = !dut_data_oe_n ? dut_data : boot_mode ? boot_word : (sel && !rd_n) ? rd_word : ~last_ff;
   // Ready is active high to peripherals and active low on host-port cycles
   assign ready_pin = !dut_rdy_oe_n ? dut_rdy : (sel && lag_ff >= ready_lag) ^ ready_low;
endmodule // xbpm_far_model

// file: verif/tb_expansion_bus_pin_modes.sv
// Self-checking bench for the expansion bus pin-mode controller.
// Assumes xbpm_core, the far side model and the bound checker are compiled.
`timescale 1ns/1ps
module tb_expansion_bus_pin_modes;
   reg         sys_clk = 1'b0, reset_n = 1'b0, boot_mode = 1'b1, ready_low = 1'b0;
   reg         req_valid = 1'b0, req_last = 1'b0, exp_backoff_in = 1'b0, host_req = 1'b0;
   reg         ext_grant = 1'b1, dir_in = 1'b0, blast_in = 1'b0, as_in_n = 1'b1, tgt_ready = 1'b1;
   reg  [2:0]  req_kind = 3'h0;
   reg  [1:0]  req_space = 2'h0;
   reg  [3:0]  req_addr = 4'h0, req_lanes = 4'hf, ready_lag = 4'h0, lanes;
   reg  [31:0] req_wdata = 32'h0000_0000, rd_word = 32'h0000_0000, boot_w = 32'h0000_0000;
   reg  [31:0] seed = 32'hea91_7d69;
   wire [31:0] data_pins, dpins_out, rdata_ff, boot_word_ff;
   wire [3:0]  exp_lane_pins_ff, cs_n;
   wire        req_ready_ff, done_ff, refused_ff, host_write_ff, host_last_ff, dev_owns_ff, host_start_ff;
   wire        ready_pin, rdy_out, rdy_oe_n, data_oe_n, wr_n, rd_n, as_n;
   int         failures = 0, checks_done = 0, n, wlow, asf, i;
   bit         rf, prev;
   ////////////////////////////////////////////////////////////////
   xbpm_core DUT (.sys_clk, .reset_n, .exp_data_pins_in(data_pins), .req_valid, .req_kind, .req_space, .req_addr,
      .req_lanes, .req_last, .req_wdata, .exp_ready_pin_in(ready_pin), .exp_backoff_in, .host_req, .ext_grant,
      .exp_direction_pin_in(dir_in), .exp_burst_last_in(blast_in), .exp_addr_strobe_n_in(as_in_n), .tgt_ready,
      .req_ready_ff, .done_ff, .refused_ff, .rdata_ff, .boot_word_ff, .host_write_ff, .host_last_ff,
      .host_start_ff, .exp_data_pins_out(dpins_out), .exp_data_pins_oe_n(data_oe_n), .exp_lane_pins_ff,
      .exp_write_strobe_n_ff(wr_n), .exp_read_strobe_n_ff(rd_n), .exp_chip_select_n_ff(cs_n),
      .exp_addr_strobe_n_ff(as_n), .exp_direction_pin_out(), .exp_direction_pin_oe_n(), .exp_burst_last_out(),
      .exp_burst_last_oe_n(), .exp_ready_pin_out(rdy_out), .exp_ready_pin_oe_n(rdy_oe_n), .dev_owns_ff);
   xbpm_far_model u_far (.sys_clk, .reset_n, .boot_mode, .boot_word(boot_w), .rd_word, .ready_lag, .ready_low,
      .cs_n, .as_n, .rd_n, .dut_data(dpins_out), .dut_data_oe_n(data_oe_n), .dut_rdy(rdy_out),
      .dut_rdy_oe_n(rdy_oe_n), .data_pins, .ready_pin);
   // 10 MHz clock
   initial forever #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////
   // Next pseudo-random word
   function automatic [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Expected host decode {write, last} from pins {direction, burst last}
   function automatic [1:0] host_exp(input [1:0] pins, input [1:0] pol);
      host_exp = {pins[1] ^ pol[0], pins[0] ~^ pol[1]};
   endfunction
   // Count a comparison, report a mismatch at once
   task automatic chk(input bit ok, input string msg);
      checks_done++;
      if (!ok) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // Reset 20 cycles with straps held through the first edge after release
   task automatic boot(input [31:0] w);
      @(posedge sys_clk);
      {reset_n, boot_mode, boot_w} <= {2'b01, w};
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      boot_mode <= 1'b0;
      @(negedge sys_clk);
      chk(boot_word_ff === w, "boot word");
   endtask
   // One request; counts edges to the answer and watches the pins meanwhile
   task automatic xfer(input [2:0] k, input [1:0] sp);
      while (req_ready_ff !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      seed = lfsr(seed);
      {req_addr, req_lanes, req_last} <= {seed[3:0], seed[7:4] | 4'h1, seed[8]};
      {req_kind, req_space, req_wdata, rd_word, req_valid} <= {k, sp, seed, ~seed, 1'b1};
      @(posedge sys_clk);
      req_valid <= 1'b0;
      {n, wlow, asf, lanes, prev} = {32'd0, 32'd0, 32'd0, 4'hf, 1'b1};
      while (n < 300 && done_ff !== 1'b1 && refused_ff !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         wlow += (wr_n === 1'b0);
         asf += (prev && as_n === 1'b0);
         prev = (as_n !== 1'b0);
         if (exp_lane_pins_ff !== 4'hf) lanes = exp_lane_pins_ff;
      end
      rf = (refused_ff === 1'b1);
   endtask
   // Print counts and verdict, then stop
   task automatic results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Scenarios: glueless on, external arbiter, ready unused
   initial begin
      boot({seed[31:5], 5'b01000});
      for (i = 0; i < 4; i++) begin
         xfer(3'h0, i[1:0]);
         chk(rf === (i != 3) && (i == 3 || n == 1), "glueless space");
      end
      chk(rdata_ff === rd_word, "fifo read data");
      // A slow peripheral must not stretch cycles that ignore ready
      ready_lag <= 4'd9;
      for (i = 1; i < 4; i++) begin
         xfer(i[2:0], i[1:0]);
         chk(n == 7 && (i != 1 || wlow == 3), "fixed strobe timing");
         chk(lanes === (i == 1 ? req_addr : ~req_lanes), "lane pins");
         if (i == 2) chk(rdata_ff === rd_word, "async read data");
      end
      // Device as master; target slow enough that the wait output shows
      {ready_low, ready_lag} <= {1'b1, 4'd6};
      for (i = 4; i < 6; i++) begin
         xfer(i[2:0], 2'h0);
         chk(done_ff === 1'b1 && lanes === ~req_lanes && wlow > 0, "master cycle");
      end
      // Back-off in mid-cycle: bus released, the cycle runs again
      fork
         xfer(3'h5, 2'h0);
         begin
            repeat (4) @(posedge sys_clk);
            exp_backoff_in <= 1'b1;
            repeat (2) @(posedge sys_clk);
            exp_backoff_in <= 1'b0;
         end
      join
      chk(done_ff === 1'b1 && asf == 2, "retry after back-off");
      // External arbiter holds the device off until it grants
      fork
         xfer(3'h4, 2'h0);
         begin
            @(posedge sys_clk) ext_grant <= 1'b0;
            repeat (20) @(posedge sys_clk);
            ext_grant <= 1'b1;
         end
      join
      chk(done_ff === 1'b1 && n > 14, "external grant");
      // Second boot: random polarities, internal arbiter, ready used
      boot({seed[31:5], 3'b101, seed[1:0]});
      {ready_low, ready_lag} <= {1'b0, 4'd5};
      xfer(3'h2, 2'h2);
      chk(n > 7 && rdata_ff === rd_word, "ready stretches the read");
      // Host owns the bus: decode of its pins and our ready as target
      @(posedge sys_clk) host_req <= 1'b1;
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         @(posedge sys_clk);
         {dir_in, blast_in, as_in_n, tgt_ready} <= {seed[1:0], 1'b0, seed[2]};
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         chk({host_write_ff, host_last_ff} === host_exp(seed[1:0], boot_w[1:0]), "host decode");
         chk(dev_owns_ff === 1'b0 && rdy_oe_n === 1'b0 && rdy_out === !seed[2], "target ready");
         chk(host_start_ff === 1'b1, "host start");
      end
      @(posedge sys_clk);
      {host_req, as_in_n, ready_low} <= 3'b011;
      xfer(3'h5, 2'h0);
      chk(done_ff === 1'b1, "internal arbiter grant");
      results;
   end
   // Watchdog: the run needs well under 2000 cycles
   initial begin
      #(4000 * 100);
      failures++;
      results;
   end
endmodule // tb_expansion_bus_pin_modes
